// ==== bench/pfd_pixel_format_bench.sv ====
// Purpose: Self-checking bench for the pixel formatting datapath
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes:   Expected values are worked out by hand from the lane formulas
`default_nettype none

module pfd_pixel_format_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk = 1'b0, rst = 1'b1, valid = 1'b0, fpu_on = 1'b1;
   logic [8:0]  subop = 9'h0;
   logic [63:0] src1 = 64'h0, src2 = 64'h0;
   logic [4:0]  scale = 5'h0;
   logic [63:0] result, dest;
   logic        res_valid, trap, order_err;
   int          mismatches = 0, compares = 0;

   always #50 clk = ~clk;

   pfd_pixel_format dut (
      .SYS_CLK_I(clk), .RST_I(rst), .VALID_I(valid), .SUBOP_I(subop),
      .FIRST_SOURCE_REG_I(src1), .SECOND_SOURCE_REG_I(src2),
      .GRAPHICS_SCALE_SHIFT_I(scale), .FLOAT_UNIT_ON_I(fpu_on),
      .RESULT_O(result), .RESULT_VALID_O(res_valid),
      .FLOAT_UNIT_OFF_TRAP_O(trap), .ORDER_ERR_O(order_err));

   pfd_writeback_model model (
      .clk_i(clk), .rst_i(rst), .result_valid_i(res_valid), .result_i(result), .dest_o(dest));

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic drive(input logic [8:0] op, input logic [63:0] a, input logic [63:0] b,
                        input logic [4:0] sc);
      valid = 1'b1;
      subop = op;
      src1 = a;
      src2 = b;
      scale = sc;
   endtask

   // One issue, then the answer one edge later
   task automatic run(input logic [8:0] op, input logic [63:0] a, input logic [63:0] b,
                      input logic [4:0] sc, input logic [63:0] exp);
      @(posedge clk) #1;
      drive(op, a, b, sc);
      @(posedge clk) #1;
      valid = 1'b0;
      chk(res_valid, 64'h1);
      chk(result, exp);
      @(posedge clk) #1;
      chk(dest, exp);
      chk(res_valid, 64'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_half();
      run(pfd_pkg::PFD_OP_PACK_HALF, 64'h0, 64'h4000_7FFF_FF80_0080, 5'h00, 64'h80FF0001);
      run(pfd_pkg::PFD_OP_PACK_HALF, 64'h0, 64'h0100_0000_007F_FFFF, 5'h00, 64'h02000000);
      run(pfd_pkg::PFD_OP_PACK_HALF, 64'h0, 64'h0010_0100_0008_0007, 5'h04, 64'h02200100);
      run(pfd_pkg::PFD_OP_PACK_HALF, 64'h0, 64'h0000_0000_FFFF_0001, 5'h1F, 64'h000000FF);
   endtask

   task automatic t_word();
      run(pfd_pkg::PFD_OP_PACK_WORD, 64'h11223344_55667788, 64'h7FFFFFFF_FF000000, 5'h00,
          64'h223344FF_66778800);
      run(pfd_pkg::PFD_OP_PACK_WORD, 64'h0, 64'h00800000_007FFFFF, 5'h01, 64'h00000002_00000001);
   endtask

   task automatic t_fix();
      run(pfd_pkg::PFD_OP_PACK_FIX, 64'h0, 64'h00018000_FFFF8000, 5'h00, 64'h0001FFFF);
      run(pfd_pkg::PFD_OP_PACK_FIX, 64'h0, 64'h7FFFFFFF_80000000, 5'h01, 64'h7FFF8000);
      run(pfd_pkg::PFD_OP_PACK_FIX, 64'h0, 64'h00000000_40000000, 5'h01, 64'h00007FFF);
   endtask

   task automatic t_expand();
      run(pfd_pkg::PFD_OP_EXPAND, 64'h0, 64'hDEADBEEF_FFAB3412, 5'h07, 64'h0FF00AB003400120);
   endtask

   task automatic t_merge();
      run(pfd_pkg::PFD_OP_INTERLEAVE, 64'hFFFF_11223344, 64'hEEEE_55667788, 5'h00,
          64'h1155226633774488);
      run(pfd_pkg::PFD_OP_INTERLEAVE, 64'h11552266, 64'h33774488, 5'h00,
          64'h1133557722446688);
   endtask

   // Interleave on three adjacent cycles: accepted, refused, accepted
   task automatic t_clash();
      @(posedge clk) #1;
      drive(pfd_pkg::PFD_OP_INTERLEAVE, 64'h04030201, 64'h08070605, 5'h00);
      @(posedge clk) #1;
      chk(result, 64'h0408_0307_0206_0105);
      src1 = 64'hAAAAAAAA;
      @(posedge clk) #1;
      chk(order_err, 64'h1);
      chk(res_valid, 64'h0);
      chk(result, 64'h0408_0307_0206_0105);
      src1 = 64'h44332211;
      @(posedge clk) #1;
      valid = 1'b0;
      chk(res_valid, 64'h1);
      chk(result, 64'h4408_3307_2206_1105);
   endtask

   // Unit off traps, unknown opcode does nothing
   task automatic t_refuse();
      logic [8:0] ops[5];
      ops = '{pfd_pkg::PFD_OP_PACK_HALF, pfd_pkg::PFD_OP_PACK_WORD, pfd_pkg::PFD_OP_PACK_FIX,
              pfd_pkg::PFD_OP_EXPAND, pfd_pkg::PFD_OP_INTERLEAVE};
      for (int i = 0; i <= 5; i++) begin
         @(posedge clk) #1;
         drive((i == 5) ? 9'h000 : ops[i], 64'h1, 64'h0000_0080_0000_0080, 5'h00);
         fpu_on = (i == 5);
         @(posedge clk) #1;
         valid = 1'b0;
         fpu_on = 1'b1;
         chk(trap, (i == 5) ? 64'h0 : 64'h1);
         chk(res_valid, 64'h0);
         chk(result, 64'h4408_3307_2206_1105);
         chk(dest, 64'h4408_3307_2206_1105);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Closing and main sequence
   task automatic summarize();
      if (mismatches == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      #100000;
      mismatches++;
      summarize();
   end

   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      chk({res_valid, trap, order_err}, 64'h0);
      chk(result, 64'h0);
      t_half();
      t_word();
      t_fix();
      t_expand();
      t_merge();
      t_clash();
      t_refuse();
      summarize();
   end

endmodule // pfd_pixel_format_bench

`default_nettype wire

// ==== bench/pfd_writeback_model.sv ====
// Purpose: Destination register model on the far side of the pixel datapath
// Assumes: One clock; a result lands only on a result-valid pulse
// Notes:   Traps and refused issues must leave the destination untouched
`default_nettype none

module pfd_writeback_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Result from the datapath
   input  wire logic        result_valid_i,
   input  wire logic [63:0] result_i,
   // Destination register contents
   output logic      [63:0] dest_o
);
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////
   // Writeback of accepted results only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dest_o <= 64'h0;
      end else if (result_valid_i) begin
         dest_o <= result_i;
      end
   end

endmodule // pfd_writeback_model

`default_nettype wire

// ==== rtl/pfd_pixel_format.sv ====
// Purpose: Single-cycle pixel pack, expand and interleave datapath
// Assumes: Issue logic runs on SYS_CLK_I; operands are stable with VALID_I
// Notes:   Result appears one edge after issue; 32-bit results sit in the low word
//
// Summary of operation
// - Decode half-to-byte and word-merge pack opcodes
// - Decode fixed pack, expand and interleave opcodes
// - Packs shift left by scale, keeping clip info
// - Truncate fraction bits, round toward negative infinity
// - Half pack makes four bytes, 32-bit result
// - Half pack binary point between bits 7, 6
// - Byte packs: negative gives 0, over 255 gives 255
// - Word pack point between bits 23, 22
// - Word pack shifts first source words by 8
// - Fixed pack: two words, point between 16, 15
// - Fixed pack saturates to -32768 and 32767
// - Expand: byte shifted four, zero-extended to 16
// - Interleave alternates bytes of two sources
// - No interleave issued in consecutive cycles
// - Double interleave converts packed and planar orders
`default_nettype none

module pfd_pixel_format (
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_I,
   // Issue
   input  wire logic        VALID_I,
   input  wire logic [8:0]  SUBOP_I,
   input  wire logic [63:0] FIRST_SOURCE_REG_I,
   input  wire logic [63:0] SECOND_SOURCE_REG_I,
   input  wire logic [4:0]  GRAPHICS_SCALE_SHIFT_I,
   input  wire logic        FLOAT_UNIT_ON_I,
   // Result
   output logic      [63:0] RESULT_O,
   output logic             RESULT_VALID_O,
   output logic             FLOAT_UNIT_OFF_TRAP_O,
   output logic             ORDER_ERR_O
);
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////
   // Clip helpers
   function automatic logic [7:0] clip_u8(input logic signed [pfd_pkg::PFD_WIDE_W-1:0] v);
      if (v < 0) begin
         clip_u8 = 8'h00;
      end else if (v > pfd_pkg::PFD_U8_MAX) begin
         clip_u8 = 8'hFF;
      end else begin
         clip_u8 = v[7:0];
      end
   endfunction

   function automatic logic [15:0] clip_s16(input logic signed [pfd_pkg::PFD_WIDE_W-1:0] v);
      if (v < pfd_pkg::PFD_S16_MIN) begin
         clip_s16 = 16'h8000;
      end else if (v > pfd_pkg::PFD_S16_MAX) begin
         clip_s16 = 16'h7FFF;
      end else begin
         clip_s16 = v[15:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   logic is_half;
   logic is_word;
   logic is_fix;
   logic is_expand;
   logic is_merge;
   logic legal;

   always_comb begin
      is_half   = 1'b0;
      is_word   = 1'b0;
      is_fix    = 1'b0;
      is_expand = 1'b0;
      is_merge  = 1'b0;
      unique case (SUBOP_I)
         pfd_pkg::PFD_OP_PACK_HALF:  is_half   = 1'b1;
         pfd_pkg::PFD_OP_PACK_WORD:  is_word   = 1'b1;
         pfd_pkg::PFD_OP_PACK_FIX:   is_fix    = 1'b1;
         pfd_pkg::PFD_OP_EXPAND:     is_expand = 1'b1;
         pfd_pkg::PFD_OP_INTERLEAVE: is_merge  = 1'b1;
         default: ;
      endcase
   end

   assign legal = is_half | is_word | is_fix | is_expand | is_merge;

   ////////////////////////////////////////////////////////////////////////////
   // Issue acceptance
   logic prev_merge;
   logic order_clash;
   logic accept;

   assign order_clash = VALID_I & is_merge & prev_merge;
   assign accept      = VALID_I & legal & FLOAT_UNIT_ON_I & ~order_clash;

   ////////////////////////////////////////////////////////////////////////////
   // Datapath lanes
   logic [7:0]  half_byte [4];
   logic [7:0]  word_byte [2];
   logic [15:0] fix_half  [2];
   logic [63:0] res_half;
   logic [63:0] res_word;
   logic [63:0] res_fix;
   logic [63:0] res_expand;
   logic [63:0] res_merge;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_half
         logic signed [pfd_pkg::PFD_WIDE_W-1:0] ext;
         logic signed [pfd_pkg::PFD_WIDE_W-1:0] scaled;
         assign ext    = $signed({{80{SECOND_SOURCE_REG_I[16*gi+15]}},
                                  SECOND_SOURCE_REG_I[16*gi +: 16]});
         // Wide shift keeps clip info; arithmetic shift floors
         assign scaled = (ext <<< GRAPHICS_SCALE_SHIFT_I) >>> pfd_pkg::PFD_HALF_POINT;
         assign half_byte[gi] = clip_u8(scaled);
         assign res_half[8*gi +: 8]       = half_byte[gi];
         assign res_expand[16*gi +: 16]   = {4'h0, SECOND_SOURCE_REG_I[8*gi +: 8],
                                             4'h0};
         assign res_merge[16*gi +: 16]    = {FIRST_SOURCE_REG_I[8*gi +: 8],
                                             SECOND_SOURCE_REG_I[8*gi +: 8]};
      end
      for (gi = 0; gi < 2; gi++) begin : g_word
         logic signed [pfd_pkg::PFD_WIDE_W-1:0] ext;
         logic signed [pfd_pkg::PFD_WIDE_W-1:0] scaled_w;
         logic signed [pfd_pkg::PFD_WIDE_W-1:0] scaled_f;
         assign ext      = $signed({{64{SECOND_SOURCE_REG_I[32*gi+31]}},
                                    SECOND_SOURCE_REG_I[32*gi +: 32]});
         assign scaled_w = (ext <<< GRAPHICS_SCALE_SHIFT_I) >>> pfd_pkg::PFD_WORD_POINT;
         assign scaled_f = (ext <<< GRAPHICS_SCALE_SHIFT_I) >>> pfd_pkg::PFD_FIX_POINT;
         assign word_byte[gi] = clip_u8(scaled_w);
         assign fix_half[gi]  = clip_s16(scaled_f);
         assign res_word[32*gi +: 32] = {FIRST_SOURCE_REG_I[32*gi +: 24],
                                         word_byte[gi]};
         assign res_fix[16*gi +: 16]  = fix_half[gi];
      end
   endgenerate

   assign res_half[63:32] = 32'h0;
   assign res_fix[63:32]  = 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Result select
   logic [63:0] next_result;

   always_comb begin
      next_result = pfd_pkg::PFD_RESULT_RST;
      if (is_half) begin
         next_result = res_half;
      end else if (is_word) begin
         next_result = res_word;
      end else if (is_fix) begin
         next_result = res_fix;
      end else if (is_expand) begin
         next_result = res_expand;
      end else if (is_merge) begin
         next_result = res_merge;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result register
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RESULT_O       <= pfd_pkg::PFD_RESULT_RST;
         RESULT_VALID_O <= 1'b0;
      end else begin
         RESULT_VALID_O <= accept;
         if (accept) begin
            RESULT_O <= next_result;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Floating unit disabled trap
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         FLOAT_UNIT_OFF_TRAP_O <= 1'b0;
      end else begin
         FLOAT_UNIT_OFF_TRAP_O <= VALID_I & legal & ~FLOAT_UNIT_ON_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interleave spacing guard
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         prev_merge  <= 1'b0;
         ORDER_ERR_O <= 1'b0;
      end else begin
         prev_merge  <= accept & is_merge;
         ORDER_ERR_O <= order_clash & FLOAT_UNIT_ON_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   logic go;
   assign go = VALID_I & FLOAT_UNIT_ON_I;

   property p_half_decode;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_HALF |=> RESULT_VALID_O && RESULT_O[63:32] == 32'h0;
   endproperty
   a_half_decode: assert property (p_half_decode) else $error("half pack result bad");

   property p_word_merge;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_WORD |=>
         RESULT_VALID_O && RESULT_O[63:40] == $past(FIRST_SOURCE_REG_I[55:32])
         && RESULT_O[31:8] == $past(FIRST_SOURCE_REG_I[23:0]);
   endproperty
   a_word_merge: assert property (p_word_merge) else $error("word merge shift bad");

   property p_half_point;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_HALF && GRAPHICS_SCALE_SHIFT_I == 5'h0
         && SECOND_SOURCE_REG_I[15] == 1'b0 |=> RESULT_O[7:0] == $past(SECOND_SOURCE_REG_I[14:7]);
   endproperty
   a_half_point: assert property (p_half_point) else $error("half pack point wrong");

   property p_half_neg;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_HALF && GRAPHICS_SCALE_SHIFT_I == 5'h0
         && SECOND_SOURCE_REG_I[15] |=> RESULT_O[7:0] == 8'h00;
   endproperty
   a_half_neg: assert property (p_half_neg) else $error("negative not clipped to 0");

   property p_fix_sat;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_FIX && GRAPHICS_SCALE_SHIFT_I == 5'h01
         && SECOND_SOURCE_REG_I[31:30] == 2'b01 |=> RESULT_O[15:0] == 16'h7FFF;
   endproperty
   a_fix_sat: assert property (p_fix_sat) else $error("fixed pack not saturated");

   property p_expand;
      go && SUBOP_I == pfd_pkg::PFD_OP_EXPAND |=>
         RESULT_O[15:0] == {4'h0, $past(SECOND_SOURCE_REG_I[7:0]), 4'h0};
   endproperty
   a_expand: assert property (p_expand) else $error("expand lane wrong");

   property p_interleave;
      go && SUBOP_I == pfd_pkg::PFD_OP_INTERLEAVE && !prev_merge |=>
         RESULT_O[15:8] == $past(FIRST_SOURCE_REG_I[7:0])
         && RESULT_O[7:0] == $past(SECOND_SOURCE_REG_I[7:0]);
   endproperty
   a_interleave: assert property (p_interleave) else $error("interleave order wrong");

   property p_merge_gap;
      (go && SUBOP_I == pfd_pkg::PFD_OP_INTERLEAVE && !prev_merge)
         ##1 (go && SUBOP_I == pfd_pkg::PFD_OP_INTERLEAVE) |=> ORDER_ERR_O && !RESULT_VALID_O;
   endproperty
   a_merge_gap: assert property (p_merge_gap) else $error("back to back interleave taken");

   property p_trap;
      VALID_I && !FLOAT_UNIT_ON_I && SUBOP_I == pfd_pkg::PFD_OP_EXPAND |=>
         FLOAT_UNIT_OFF_TRAP_O && !RESULT_VALID_O && $stable(RESULT_O);
   endproperty
   a_trap: assert property (p_trap) else $error("disabled unit wrote result");

   property p_word_point;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_WORD && GRAPHICS_SCALE_SHIFT_I == 5'h01
         && SECOND_SOURCE_REG_I[31:30] == 2'b00 |=>
         RESULT_O[7:0] == $past(SECOND_SOURCE_REG_I[29:22]);
   endproperty
   a_word_point: assert property (p_word_point) else $error("word pack point wrong");

   property p_fix_floor;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_FIX && GRAPHICS_SCALE_SHIFT_I == 5'h00 |=>
         RESULT_O[15:0] == $past(SECOND_SOURCE_REG_I[31:16])
         && RESULT_O[31:16] == $past(SECOND_SOURCE_REG_I[63:48]);
   endproperty
   a_fix_floor: assert property (p_fix_floor) else $error("fixed pack floor wrong");

   property p_fix_upper;
      go && SUBOP_I == pfd_pkg::PFD_OP_PACK_FIX |=> RESULT_VALID_O && RESULT_O[63:32] == 32'h0;
   endproperty
   a_fix_upper: assert property (p_fix_upper) else $error("fixed pack high word set");

   property p_expand_top;
      go && SUBOP_I == pfd_pkg::PFD_OP_EXPAND |=>
         RESULT_O[63:48] == {4'h0, $past(SECOND_SOURCE_REG_I[31:24]), 4'h0};
   endproperty
   a_expand_top: assert property (p_expand_top) else $error("expand top lane wrong");

   property p_illegal_quiet;
      VALID_I && !(SUBOP_I inside {pfd_pkg::PFD_OP_PACK_HALF, pfd_pkg::PFD_OP_PACK_WORD,
                                   pfd_pkg::PFD_OP_PACK_FIX, pfd_pkg::PFD_OP_EXPAND,
                                   pfd_pkg::PFD_OP_INTERLEAVE}) |=>
         !RESULT_VALID_O && !FLOAT_UNIT_OFF_TRAP_O && !ORDER_ERR_O && $stable(RESULT_O);
   endproperty
   a_illegal_quiet: assert property (p_illegal_quiet) else $error("stray opcode acted");

   c_half:  cover property (go && SUBOP_I == pfd_pkg::PFD_OP_PACK_HALF ##1 RESULT_VALID_O);
   c_merge: cover property (ORDER_ERR_O);
   c_trap:  cover property (FLOAT_UNIT_OFF_TRAP_O);
   c_fix:   cover property (go && SUBOP_I == pfd_pkg::PFD_OP_PACK_FIX ##1 RESULT_VALID_O);

endmodule // pfd_pixel_format

`default_nettype wire

// ==== rtl/pfd_pkg.sv ====
// Purpose: Constants and sub-opcode encodings for the pixel formatting datapath
// Assumes: Sub-opcodes arrive already decoded out of the instruction word
// Notes:   Binary points and clip limits live here; lane field positions are fixed in the datapath
`default_nettype none

package pfd_pkg;
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int PFD_OP_W    = 9;
   localparam int PFD_DATA_W  = 64;
   localparam int PFD_SCALE_W = 5;
   localparam int PFD_WIDE_W  = 96;

   ////////////////////////////////////////////////////////////////////////////
   // Sub-opcodes
   typedef enum logic [PFD_OP_W-1:0] {
      PFD_OP_PACK_HALF  = 9'b0_0011_1011,
      PFD_OP_PACK_WORD  = 9'b0_0011_1010,
      PFD_OP_PACK_FIX   = 9'b0_0011_1101,
      PFD_OP_EXPAND     = 9'b0_0100_1101,
      PFD_OP_INTERLEAVE = 9'b0_0100_1011
   } pfd_op_e;

   ////////////////////////////////////////////////////////////////////////////
   // Implicit binary points after scaling
   localparam int PFD_HALF_POINT = 7;
   localparam int PFD_WORD_POINT = 23;
   localparam int PFD_FIX_POINT  = 16;

   // Left shift applied by the byte expand
   localparam int PFD_EXPAND_SHIFT = 4;

   // Left shift of each first-source word in the pack-and-merge
   localparam int PFD_MERGE_SHIFT = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Clip limits
   localparam logic signed [PFD_WIDE_W-1:0] PFD_U8_MAX  = 96'sh0FF;
   localparam logic signed [PFD_WIDE_W-1:0] PFD_S16_MAX = 96'sh7FFF;
   localparam logic signed [PFD_WIDE_W-1:0] PFD_S16_MIN = -96'sh8000;

   // Reset values
   localparam logic [PFD_DATA_W-1:0] PFD_RESULT_RST = 64'h0;

endpackage : pfd_pkg

`default_nettype wire
